// ===== core/cgsc_regs.vh
/*
 * Constants of the clock generator serial control block: register
 * indices, field positions, power-up values, bus codes and dividers.
 * Assumes inclusion by cgsc_top.v only, by bare name.
 */
`ifndef CGSC_REGS_VH
`define CGSC_REGS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CGSC_IDX_FUNCTION_SELECT 2'h0
`define CGSC_IDX_BANK_A_REF_EN 2'h1
`define CGSC_IDX_BANK_B_EN 2'h2

// ----------------------------------------
// Field positions, function select and bank A/ref enables
// ----------------------------------------
`define CGSC_BIT_TEST_MODE_SELECT 7
`define CGSC_BIT_SPREAD_ENABLE 6
`define CGSC_BIT_SPREAD_WIDTH 5
`define CGSC_BIT_B_CODE_HIGH 4
`define CGSC_BIT_B_CODE_LOW 3
`define CGSC_BIT_A_CODE_HIGH 2
`define CGSC_BIT_A_CODE_LOW 1
`define CGSC_BIT_PIN_CONTROL 0
`define CGSC_BIT_REF_OUT_ENABLE 5

// ----------------------------------------
// Power-up values
// ----------------------------------------
`define CGSC_RST_FUNCTION_SELECT 8'hA1
`define CGSC_RST_BANK_A_REF_EN 8'hFF
`define CGSC_RST_BANK_B_EN 8'hFF

// ----------------------------------------
// Bus codes (8-bit write addresses by strap)
// ----------------------------------------
`define CGSC_CMD_BLOCK 8'h00
`define CGSC_ADDR_000 8'hDE
`define CGSC_ADDR_100 8'hDC
`define CGSC_ADDR_010 8'hDA
`define CGSC_ADDR_110 8'hD8
`define CGSC_ADDR_001 8'hD6
`define CGSC_ADDR_101 8'hD4
`define CGSC_ADDR_011 8'hD0
`define CGSC_ADDR_111 8'hD2
`define CGSC_LAST_DATA_INDEX 2'h2

// ----------------------------------------
// Test mode dividers (rising edges of input clock per period, and per half period)
// ----------------------------------------
`define CGSC_TEST_DIV_A 6
`define CGSC_TEST_DIV_B 4
`define CGSC_TEST_HALF_A 3'h3
`define CGSC_TEST_HALF_B 3'h2

`endif

// ===== core/cgsc_top.v
/*
 * Serial control slave and control register bank of a clock generator.
 * Three write-only control bytes steer frequency codes, spread, test
 * mode and per-output enables. Assumes bus and strap inputs synchronous
 * to core_clk and the output clock levels visible as inputs.
 */
`timescale 1ns/100ps
`include "cgsc_regs.vh"

module cgsc_top #(
	parameter NUM_OUT = 5
) (
	input wire core_clk,
	input wire sys_rst,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire [2:0] addr_strap,
	input wire [1:0] bank_a_freq_pins,
	input wire [1:0] bank_b_freq_pins,
	input wire spread_pin_n,
	input wire bank_a_output_enable_pin,
	input wire bank_b_output_enable_pin,
	input wire xin_level,
	input wire bank_a_clk_level,
	input wire bank_b_clk_level,
	input wire ref_clk_level,
	output reg test_mode,
	output reg [1:0] bank_a_freq_code,
	output reg [1:0] bank_b_freq_code,
	output reg spread_on,
	output reg spread_half_width,
	output reg freq_from_xin,
	output reg [NUM_OUT-1:0] bank_a_clocks_oe,
	output reg [NUM_OUT-1:0] bank_b_clocks_oe,
	output reg ref_out_oe,
	output reg test_clk_a,
	output reg test_clk_b,
	output reg test_clk_ref
);

	// ----------------------------------------
	// Bus slave states
	// ----------------------------------------
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_RX = 4'h2;
	localparam [3:0] ST_ACK = 4'h4;
	localparam [3:0] ST_SKIP = 4'h8;

	reg [3:0] state_reg;
	reg scl_prev_reg;
	reg sda_prev_reg;
	reg [7:0] shift_reg;
	reg [3:0] bit_cnt_reg;
	reg [1:0] phase_reg;
	reg [1:0] data_idx_reg;
	reg ack_pending_reg;
	reg [7:0] function_select_reg;
	reg [7:0] bank_a_ref_output_enables_reg;
	reg [7:0] bank_b_output_enables_reg;
	reg [7:0] my_addr_reg;
	reg [7:0] byte_next;

	wire scl_rise = scl_in & ~scl_prev_reg;
	wire scl_fall = ~scl_in & scl_prev_reg;
	wire start_det = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
	wire stop_det = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;

	// ----------------------------------------
	// Address strap decode
	// ----------------------------------------
	// strap to address
	always @(posedge core_clk) begin
		if (sys_rst) begin
			my_addr_reg <= `CGSC_ADDR_000;
		end else begin
			case ({addr_strap[2], addr_strap[1], addr_strap[0]})
				3'h0: my_addr_reg <= `CGSC_ADDR_000;
				3'h1: my_addr_reg <= `CGSC_ADDR_100;
				3'h2: my_addr_reg <= `CGSC_ADDR_010;
				3'h3: my_addr_reg <= `CGSC_ADDR_110;
				3'h4: my_addr_reg <= `CGSC_ADDR_001;
				3'h5: my_addr_reg <= `CGSC_ADDR_101;
				3'h6: my_addr_reg <= `CGSC_ADDR_011;
				default: my_addr_reg <= `CGSC_ADDR_111;
			endcase
		end
	end
	always @* begin
		byte_next = {shift_reg[6:0], sda_in};
	end

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			phase_reg <= 2'h0;
			data_idx_reg <= 2'h0;
			ack_pending_reg <= 1'b0;
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
			function_select_reg <= `CGSC_RST_FUNCTION_SELECT;
			bank_a_ref_output_enables_reg <= `CGSC_RST_BANK_A_REF_EN;
			bank_b_output_enables_reg <= `CGSC_RST_BANK_B_EN;
		end else begin
			scl_prev_reg <= scl_in;
			sda_prev_reg <= sda_in;
			sda_out <= 1'b0;
			if (stop_det) begin
				state_reg <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (start_det) begin
				state_reg <= ST_RX;
				bit_cnt_reg <= 4'h0;
				phase_reg <= 2'h0;
				data_idx_reg <= 2'h0;
				ack_pending_reg <= 1'b0;
				sda_oe <= 1'b0;
			end else begin
				case (state_reg)
					ST_IDLE, ST_SKIP: begin
						sda_oe <= 1'b0;
					end
					ST_RX: begin
						if (scl_rise) begin
							shift_reg <= byte_next;
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == 4'h7) begin
								ack_pending_reg <= 1'b1;
								case (phase_reg)
									2'h0: begin
										ack_pending_reg <= (byte_next == my_addr_reg);
										phase_reg <= 2'h1;
									end
									2'h1: begin
										ack_pending_reg <= (byte_next == `CGSC_CMD_BLOCK);
										phase_reg <= 2'h2;
									end
									2'h2: begin
										phase_reg <= 2'h3;
									end
									default: begin
										case (data_idx_reg)
											`CGSC_IDX_FUNCTION_SELECT:
												function_select_reg <= byte_next;
											`CGSC_IDX_BANK_A_REF_EN:
												bank_a_ref_output_enables_reg <= byte_next;
											`CGSC_IDX_BANK_B_EN:
												bank_b_output_enables_reg <= byte_next;
											default: begin
											end
										endcase
										if (data_idx_reg != 2'h3) begin
											data_idx_reg <= data_idx_reg + 2'h1;
										end
									end
								endcase
							end
						end else if (scl_fall && bit_cnt_reg == 4'h8) begin
							bit_cnt_reg <= 4'h0;
							if (ack_pending_reg) begin
								state_reg <= ST_ACK;
								sda_oe <= 1'b1;
							end else begin
								state_reg <= ST_SKIP;
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							state_reg <= ST_RX;
						end
					end
					default: begin
						state_reg <= ST_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Effective controls
	// ----------------------------------------
	wire pin_ctrl = function_select_reg[`CGSC_BIT_PIN_CONTROL];
	wire spread_sel = pin_ctrl ? ~spread_pin_n : function_select_reg[`CGSC_BIT_SPREAD_ENABLE];

	always @(posedge core_clk) begin
		if (sys_rst) begin
			test_mode <= 1'b0;
			bank_a_freq_code <= 2'h0;
			bank_b_freq_code <= 2'h0;
			spread_on <= 1'b0;
			spread_half_width <= 1'b1;
			freq_from_xin <= 1'b0;
		end else begin
			test_mode <= ~function_select_reg[`CGSC_BIT_TEST_MODE_SELECT];
			bank_a_freq_code <= pin_ctrl ? bank_a_freq_pins :
				{function_select_reg[`CGSC_BIT_A_CODE_HIGH],
				function_select_reg[`CGSC_BIT_A_CODE_LOW]};
			bank_b_freq_code <= pin_ctrl ? bank_b_freq_pins :
				{function_select_reg[`CGSC_BIT_B_CODE_HIGH],
				function_select_reg[`CGSC_BIT_B_CODE_LOW]};
			spread_on <= spread_sel;
			spread_half_width <= function_select_reg[`CGSC_BIT_SPREAD_WIDTH];
			freq_from_xin <= ~spread_sel & function_select_reg[`CGSC_BIT_SPREAD_WIDTH];
		end
	end

	// ----------------------------------------
	// Test mode dividers
	// ----------------------------------------
	reg xin_prev_reg;
	reg [2:0] div_a_reg;
	reg [2:0] div_b_reg;
	wire xin_rise = xin_level & ~xin_prev_reg;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			xin_prev_reg <= 1'b0;
			div_a_reg <= 3'h0;
			div_b_reg <= 3'h0;
			test_clk_a <= 1'b0;
			test_clk_b <= 1'b0;
			test_clk_ref <= 1'b0;
		end else begin
			xin_prev_reg <= xin_level;
			test_clk_ref <= test_mode & xin_level;
			if (!test_mode) begin
				div_a_reg <= 3'h0;
				div_b_reg <= 3'h0;
				test_clk_a <= 1'b0;
				test_clk_b <= 1'b0;
			end else if (xin_rise) begin
				if (div_a_reg == `CGSC_TEST_HALF_A - 3'h1) begin
					div_a_reg <= 3'h0;
					test_clk_a <= ~test_clk_a;
				end else begin
					div_a_reg <= div_a_reg + 3'h1;
				end
				if (div_b_reg == `CGSC_TEST_HALF_B - 3'h1) begin
					div_b_reg <= 3'h0;
					test_clk_b <= ~test_clk_b;
				end else begin
					div_b_reg <= div_b_reg + 3'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Output enables
	// ----------------------------------------
	// Gated copies change only while the clock is low, so no runt pulse
	reg [NUM_OUT-1:0] gate_a_reg;
	reg [NUM_OUT-1:0] gate_b_reg;
	reg gate_ref_reg;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			gate_a_reg <= {NUM_OUT{1'b1}};
			gate_b_reg <= {NUM_OUT{1'b1}};
			gate_ref_reg <= 1'b1;
			bank_a_clocks_oe <= {NUM_OUT{1'b0}};
			bank_b_clocks_oe <= {NUM_OUT{1'b0}};
			ref_out_oe <= 1'b0;
		end else begin
			if (!bank_a_clk_level) begin
				gate_a_reg <= bank_a_ref_output_enables_reg[NUM_OUT-1:0];
			end
			if (!bank_b_clk_level) begin
				gate_b_reg <= bank_b_output_enables_reg[NUM_OUT-1:0];
			end
			if (!ref_clk_level) begin
				gate_ref_reg <= bank_a_ref_output_enables_reg[`CGSC_BIT_REF_OUT_ENABLE];
			end
			bank_a_clocks_oe <= gate_a_reg & {NUM_OUT{bank_a_output_enable_pin}};
			bank_b_clocks_oe <= gate_b_reg & {NUM_OUT{bank_b_output_enable_pin}};
			ref_out_oe <= gate_ref_reg & bank_a_output_enable_pin & bank_b_output_enable_pin;
		end
	end

endmodule

// ===== dv/cgsc_checker.sv
/* Port checker for cgsc_top, attached by bind below.
 Assumes one clock, core_clk, and synchronous reset sys_rst. */
`timescale 1ns/100ps
module cgsc_checker #(
	parameter NUM_OUT = 5
) (
	input wire core_clk,
	input wire sys_rst,
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe,
	input wire bank_a_output_enable_pin,
	input wire bank_b_output_enable_pin,
	input wire bank_a_clk_level,
	input wire test_mode,
	input wire spread_on,
	input wire freq_from_xin,
	input wire [NUM_OUT-1:0] bank_a_clocks_oe,
	input wire [NUM_OUT-1:0] bank_b_clocks_oe,
	input wire ref_out_oe,
	input wire test_clk_a,
	input wire test_clk_b,
	input wire test_clk_ref
);
	// ------
	// Properties
	// ------
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	reset_state_a:
		assert property (disable iff (1'b0) sys_rst |=> !sda_oe && !test_mode && bank_a_clocks_oe == 0)
		else $error("state not cleared by reset");
	ack_low_a:
		assert property (sda_oe |-> !sda_out) else $error("data driven high");
	ack_start_a:
		assert property ($rose(sda_oe) |-> !scl_in ##1 sda_oe [*2]) else $error("ack slot wrong");
	ack_hold_a:
		assert property (sda_oe && scl_in |=> sda_oe) else $error("ack dropped with clock high");
	ack_end_a:
		assert property ($rose(sda_oe) |-> ##[1:200] $fell(sda_oe)) else $error("ack never ends");
	pin_a_off_a:
		assert property (!bank_a_output_enable_pin |=> bank_a_clocks_oe == 0)
		else $error("bank a still driven");
	pin_b_off_a:
		assert property (!bank_b_output_enable_pin |=> bank_b_clocks_oe == 0 && !ref_out_oe)
		else $error("bank b or ref still driven");
	gate_low_a:
		assert property ($changed(bank_a_clocks_oe) && $past(bank_a_output_enable_pin)
			&& $past(bank_a_output_enable_pin, 2) && !$past(sys_rst) && !$past(sys_rst, 2)
			|-> !$past(bank_a_clk_level, 2))
		else $error("enable changed with clock high");
	test_idle_a:
		assert property (!test_mode && !$past(test_mode) |-> !test_clk_a && !test_clk_b && !test_clk_ref)
		else $error("test clock outside test mode");
	src_excl_a:
		assert property (freq_from_xin |-> !spread_on) else $error("source and spread both set");
	cover property ($rose(sda_oe));
	cover property ($rose(test_clk_a));
	cover property ($fell(ref_out_oe));
endmodule

bind cgsc_top cgsc_checker #(.NUM_OUT(NUM_OUT)) chk_i (.core_clk, .sys_rst, .scl_in, .sda_out,
	.sda_oe, .bank_a_output_enable_pin, .bank_b_output_enable_pin, .bank_a_clk_level,
	.test_mode, .spread_on, .freq_from_xin, .bank_a_clocks_oe, .bank_b_clocks_oe,
	.ref_out_oe, .test_clk_a, .test_clk_b, .test_clk_ref);

// ===== dv/cgsc_host.sv
/* Behavioural SMBus host, write frames only.
 Assumes the bench wires the data line with pull-up and slave pull-down. */
`timescale 1ns/100ps
module cgsc_host (
	input wire core_clk,
	input wire sda_line,
	output reg scl,
	output reg sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// ------
	// Bus phases
	// ------
	task half;
		repeat (4) @(posedge core_clk);
	endtask
	task start;
		sda <= 1'b0;
		half;
		scl <= 1'b0;
		half;
	endtask
	task bits(input [7:0] d, input integer n);
		integer i;
		for (i = 7; i > 7 - n; i--) begin
			sda <= d[i];
			half;
			scl <= 1'b1;
			half;
			scl <= 1'b0;
			half;
		end
	endtask
	task byte_ack(input [7:0] d, output a);
		bits(d, 8);
		sda <= 1'b1;
		half;
		scl <= 1'b1;
		half;
		a = !sda_line;
		scl <= 1'b0;
		half;
	endtask
	// ascending bytes, stop after any bit
	task frame(input [7:0] adr, input [31:0] d, input integer n, input integer part,
		output integer acks);
		reg [55:0] v;
		reg a;
		integer k;
		v = {adr, 8'h00, n[7:0], d};
		acks = 0;
		start;
		for (k = 0; k < n + 3; k++) begin
			byte_ack(v[55 - 8 * k -: 8], a);
			acks += a;
		end
		if (part > 0)
			bits(8'h00, part);
		sda <= 1'b0;
		half;
		scl <= 1'b1;
		half;
		sda <= 1'b1;
		half;
	endtask
endmodule

// ===== dv/test_clock_gen_smbus_control.sv
/* Self-checking bench for cgsc_top with a behavioural SMBus host.
 Assumes cgsc_host, cgsc_checker and the core files compiled first. */
`timescale 1ns/100ps
module test_clock_gen_smbus_control;
	reg core_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [2:0] strap = 3'h0;
	reg oe_a = 1'b1;
	reg oe_b = 1'b1;
	reg spread_n = 1'b0;
	reg [3:0] div = 4'h0;
	reg [2:0] tc_d = 3'h0;
	reg win = 1'b0;
	reg [7:0] tbl [0:7] = '{8'hDE, 8'hDC, 8'hDA, 8'hD8, 8'hD6, 8'hD4, 8'hD0, 8'hD2};
	integer na = 0, nb = 0, nr = 0, acks, s;
	integer miscompares = 0;
	integer compares = 0;
	wire scl, sda_h, sda_oe, sda_out, test_mode, spread_on, half_w, from_xin, ref_oe, tca, tcb, tcr;
	wire [1:0] a_code, b_code;
	wire [4:0] a_oe, b_oe;
	wire sda_line = sda_h & ~(sda_oe & ~sda_out);
	wire [7:0] ctl = {test_mode, a_code, b_code, spread_on, half_w, from_xin};
	wire [10:0] oes = {ref_oe, a_oe, b_oe};
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		div <= div + 4'h1;
		tc_d <= {tca, tcb, tcr};
		if (win) begin
			na <= na + (tca & ~tc_d[2]);
			nb <= nb + (tcb & ~tc_d[1]);
			nr <= nr + (tcr & ~tc_d[0]);
		end
	end
	cgsc_host host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda(sda_h));
	cgsc_top #(.NUM_OUT(5)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(strap),
		.bank_a_freq_pins(2'h2), .bank_b_freq_pins(2'h1), .spread_pin_n(spread_n),
		.bank_a_output_enable_pin(oe_a), .bank_b_output_enable_pin(oe_b), .xin_level(div[1]),
		.bank_a_clk_level(div[2]), .bank_b_clk_level(div[3]), .ref_clk_level(div[1]),
		.test_mode(test_mode), .bank_a_freq_code(a_code), .bank_b_freq_code(b_code),
		.spread_on(spread_on), .spread_half_width(half_w), .freq_from_xin(from_xin),
		.bank_a_clocks_oe(a_oe), .bank_b_clocks_oe(b_oe), .ref_out_oe(ref_oe),
		.test_clk_a(tca), .test_clk_b(tcb), .test_clk_ref(tcr));
	// ------
	// Tasks
	// ------
	task chk(input string name, input [15:0] exp, input [15:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %0s expected %h seen %h", name, exp, got);
		end
	endtask
	task wait_n(input integer n);
		repeat (n) @(posedge core_clk);
	endtask
	task t_block;
		host.frame(8'hDE, 32'hD2EAF500, 4, 0, acks);
		chk("acks", 16'd7, acks[15:0]);
		wait_n(12);
		chk("ctl", 16'h34, ctl);
		chk("oes", 16'h555, oes);
		host.frame(8'hDE, 32'h8E000000, 1, 4, acks);
		wait_n(12);
		chk("ctl", 16'h68, ctl);
		chk("oes", 16'h555, oes);
	endtask
	task t_strap;
		for (s = 0; s < 8; s++) begin
			strap <= s[2:0];
			wait_n(4);
			host.frame(tbl[s], 32'h0, 0, 0, acks);
			chk("acks", 16'd3, acks[15:0]);
			host.frame(tbl[s] | 8'h01, 32'h0, 0, 0, acks);
			chk("acks", 16'd0, acks[15:0]);
			host.frame(tbl[(s + 1) % 8], 32'h0, 1, 0, acks);
			chk("acks", 16'd0, acks[15:0]);
		end
		wait_n(12);
		chk("ctl", 16'h68, ctl);
	endtask
	task t_oe;
		oe_a <= 1'b0;
		wait_n(4);
		chk("oes", 16'h015, oes);
		oe_a <= 1'b1;
		oe_b <= 1'b0;
		wait_n(12);
		chk("oes", 16'h140, oes);
		oe_b <= 1'b1;
		wait_n(12);
		chk("oes", 16'h555, oes);
	endtask
	task t_test;
		host.frame(8'hD2, 32'h20000000, 1, 0, acks);
		chk("acks", 16'd4, acks[15:0]);
		wait_n(12);
		chk("ctl", 16'h83, ctl);
		win <= 1'b1;
		wait_n(240);
		win <= 1'b0;
		wait_n(1);
		chk("div_a", 16'd10, na[15:0]);
		chk("div_b", 16'd15, nb[15:0]);
		chk("div_ref", 16'd60, nr[15:0]);
	endtask
	task report_and_stop;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		wait_n(8);
		sys_rst <= 1'b0;
		wait_n(12);
		chk("ctl", 16'h4E, ctl);
		chk("oes", 16'h7FF, oes);
		spread_n <= 1'b1;
		wait_n(4);
		chk("ctl", 16'h4B, ctl);
		spread_n <= 1'b0;
		wait_n(4);
		chk("ctl", 16'h4E, ctl);
		t_block;
		t_strap;
		t_oe;
		t_test;
		report_and_stop;
	end
endmodule
